// ==== core/ssr_core.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE_01 - Voltage or current ramp starts from the programmed initial level, not zero.
// RULE_02 - Ramp time sets how long the reference takes to reach its target.
// RULE_03 - Current limit holds during acceleration until at speed or overload trip.
// RULE_04 - Voltage ramp rises until current reaches limit, then current limit governs.
// RULE_05 - Current ramp closes the loop on motor current, rising linearly to maximum.
// RULE_06 - Power ramp begins at programmable initial power, twenty percent by default.
// RULE_07 - Power rises linearly from initial to maximum over whole-second ramp time.
// RULE_08 - After power limit is reached, power is regulated constant until full speed.
// RULE_09 - Maximum power is programmable, eighty percent default, capping acceleration power.
// RULE_10 - Power is computed each line cycle from voltage, current and power factor.
// RULE_11 - Kick start applies kick voltage for kick time at start when enabled.
// RULE_12 - Stop with decel steps to start voltage, ramps to stop voltage, then zero.
// RULE_13 - Timed relay energizes after timed plus run delay, drops on stop.
// RULE_14 - Run delay relay starts timing on start and drops when time expires.
// RULE_15 - At-speed relay energizes after at speed plus delay, held until stop.
// RULE_16 - Each protection raises alarm or trip only after continuous persistence for delay.
// RULE_17 - Software must set imbalance trip level above imbalance alarm level.
// RULE_18 - Enabled phase loss trips after loss persists for phase loss delay.
// RULE_19 - On start, a rotation differing from configured order trips.
// RULE_20 - Frequency outside nominal window longer than delay trips.
// RULE_21 - Leading and lagging power factor each have own alarm and trip with delays.
// RULE_22 - Current, kW, kVAR and kVA are averaged over the demand period and stored.
// RULE_23 - Nominal frequency is selectable between fifty and sixty hertz.
// RULE_24 - A protection timer clears whenever its condition drops before expiry.
// RULE_25 - All timers run from one common millisecond tick and clear on reset.
module ssr_core
	import ssr_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// AXI4-Lite write
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [31:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Line measurement, same clock
	input  wire logic        lineCycle,
	input  wire logic [15:0] lineVolt,
	input  wire logic [15:0] motorCur,
	input  wire logic [15:0] pfPct,
	input  wire logic        pfLead,
	input  wire logic [15:0] imbalance,
	input  wire logic [15:0] groundCur,
	input  wire logic [15:0] lineFreq,
	input  wire logic [15:0] kvarPct,
	input  wire logic        phaseLost,
	input  wire logic        reverseSeen,
	input  wire logic        atSpeed,
	input  wire logic        thermalTrip,
	// Firing stage and relays
	output logic [15:0]      fireLevel,
	output logic             fireEnable,
	output logic             timedRelay,
	output logic             runDelayRelay,
	output logic             atSpeedRelay,
	output logic             alarmOut,
	output logic             tripOut
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic mapped(input logic [31:0] a);
		return (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) && (a[7:0] < A_PEND);
	endfunction

	function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (d & m);
	endfunction

	// Zero seconds would make a ramp step on every clock, so clamp to one
	function automatic logic [31:0] ms1(input logic [7:0] s);
		return (s == 8'h00) ? MS_PER_S : 32'(32'(s) * MS_PER_S);
	endfunction

	function automatic logic [15:0] step(input logic [15:0] f, input logic [15:0] m,
		input logic [15:0] sp);
		if (m < sp && f < FULL_PCT) begin
			return f + 16'h0001;
		end
		if (m > sp && f > 16'h0000) begin
			return f - 16'h0001;
		end
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////
	ssr_regs_t        r;
	ssr_regs_t        n;
	logic             startCmd;
	logic             stopCmd;
	logic             tripNow;
	logic             act;
	logic [NPROT-1:0] cond;
	logic [NPROT-1:0] pEn;
	logic [31:0]      wv;
	logic [31:0]      rdv;
	logic [47:0]      prod;
	logic [15:0]      tgt;
	logic [15:0]      nom;
	logic [15:0]      dev;
	logic [31:0]      delta;
	logic [31:0]      rampMs;
	logic [31:0]      decelMs;
	logic [4:0]       wIdx;
	logic [4:0]       rIdx;
	logic [3:0][15:0] dq;
	ssr_mode_t        mode;

	always_comb begin
		n = r;
		startCmd = 1'b0;
		stopCmd = 1'b0;
		rdv = 32'h0000_0000;
		delta = 32'h0000_0000;
		tgt = FULL_PCT;
		wv = bmerge(32'h0000_0000, r.wData, r.wStrb);
		wIdx = 5'((r.awAddr[7:0] - A_PROT) >> 2);
		rIdx = 5'((araddr[7:0] - A_PROT) >> 2);
		mode = ssr_mode_t'(r.ctrl[C_MODE +: 2]);
		rampMs = ms1(r.rampSec);
		decelMs = ms1(r.decel[D_SEC +: 8]);
		prod = 48'(lineVolt) * 48'(motorCur) * 48'(pfPct);
		nom = r.ctrl[C_F60] ? FREQ60 : FREQ50; // RULE_23
		dev = (lineFreq > nom) ? lineFreq - nom : nom - lineFreq;
		dq = {r.kva, kvarPct, r.pwr, motorCur};
		for (int i = 0; i < NPROT; i++) begin
			pEn[i] = r.prot[i][P_EN];
		end

		// Common millisecond tick
		n.tick = 1'b0; // RULE_25
		if (r.tickCnt >= 32'(TICK_CYCLES - 1)) begin
			n.tickCnt = 32'h0000_0000;
			n.tick = 1'b1;
		end else begin
			n.tickCnt = r.tickCnt + 32'h0000_0001;
		end

		////////////////////////////////////////////////////////////////////
		// Bus write; takes address and data in either order
		if (awvalid && r.awready) begin
			n.awHave = 1'b1;
			n.awAddr = awaddr;
		end
		if (wvalid && r.wready) begin
			n.wHave = 1'b1;
			n.wData = wdata;
			n.wStrb = wstrb;
		end
		if (r.awHave && r.wHave && !r.bvalid) begin
			n.awHave = 1'b0;
			n.wHave = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(r.awAddr) ? RESP_OK : RESP_ERR;
			if (mapped(r.awAddr) && r.awAddr[7:0] >= A_PROT) begin
				n.prot[wIdx] = bmerge(r.prot[wIdx], r.wData, r.wStrb);
			end else if (mapped(r.awAddr)) begin
				case (r.awAddr[7:0])
					A_CTRL: begin
						n.ctrl = bmerge(r.ctrl, r.wData, r.wStrb) & CTRL_KEEP;
						startCmd = wv[C_START];
						stopCmd = wv[C_STOP];
					end
					A_INIT: n.initPct = 16'(bmerge(32'(r.initPct), r.wData, r.wStrb));
					A_LIM: n.limPct = 16'(bmerge(32'(r.limPct), r.wData, r.wStrb));
					A_MAXP: n.maxPwr = 16'(bmerge(32'(r.maxPwr), r.wData, r.wStrb)); // RULE_09
					A_RAMP: n.rampSec = 8'(bmerge(32'(r.rampSec), r.wData, r.wStrb));
					A_KICK: n.kick = bmerge(r.kick, r.wData, r.wStrb);
					A_DECEL: n.decel = bmerge(r.decel, r.wData, r.wStrb);
					A_RELAY: n.relay = bmerge(r.relay, r.wData, r.wStrb);
					A_DEM: n.demSec = 8'(bmerge(32'(r.demSec), r.wData, r.wStrb));
					// Write one to clear; a same-cycle event sets it again below
					A_EVT: n.evt = r.evt & ~wv[NEVT-1:0];
					default: ;
				endcase
			end
		end
		if (r.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		n.awready = !n.awHave;
		n.wready = !n.wHave;

		// Bus read
		if (arvalid && r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = mapped(araddr) ? RESP_OK : RESP_ERR;
			if (mapped(araddr) && araddr[7:0] >= A_PROT) begin
				rdv = r.prot[rIdx];
			end else if (mapped(araddr) && araddr[7:0] >= A_DAVG) begin
				rdv = {16'h0000, r.dAvg[araddr[3:2]]};
			end else if (mapped(araddr)) begin
				case (araddr[7:0])
					A_CTRL: rdv = r.ctrl;
					A_STAT: rdv = 32'({r.tripOut, r.alarmOut, r.atRly, r.runDlyRly,
						r.timedRly, r.fireEn, r.limHit, r.st});
					A_INIT: rdv = 32'(r.initPct);
					A_LIM: rdv = 32'(r.limPct);
					A_MAXP: rdv = 32'(r.maxPwr);
					A_RAMP: rdv = 32'(r.rampSec);
					A_KICK: rdv = r.kick;
					A_DECEL: rdv = r.decel;
					A_RELAY: rdv = r.relay;
					A_DEM: rdv = 32'(r.demSec);
					A_EVT: rdv = 32'(r.evt);
					A_FIRE: rdv = {r.rampRef, r.fire};
					default: rdv = 32'h0000_0000;
				endcase
			end
			n.rdata = rdv;
		end
		if (r.rvalid && rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// Power per line cycle, unity base from volts and full load current
		if (lineCycle) begin
			n.pwr = 16'(prod / PWR_DIV); // RULE_10
			n.kva = 16'(32'(lineVolt) * 32'(motorCur) / KVA_DIV);
		end

		// Protection conditions
		cond[P_IMB_A] = imbalance > r.prot[P_IMB_A][15:0];
		cond[P_IMB_T] = imbalance > r.prot[P_IMB_T][15:0];
		cond[P_UC_A] = (r.st == S_RUN) && motorCur < r.prot[P_UC_A][15:0];
		cond[P_OC_A] = motorCur > r.prot[P_OC_A][15:0];
		cond[P_OC_T] = motorCur > r.prot[P_OC_T][15:0];
		cond[P_GF_A] = groundCur > r.prot[P_GF_A][15:0];
		cond[P_GF_L] = groundCur > r.prot[P_GF_L][15:0];
		cond[P_GF_H] = groundCur > r.prot[P_GF_H][15:0];
		cond[P_OV_A] = lineVolt > r.prot[P_OV_A][15:0];
		cond[P_OV_T] = lineVolt > r.prot[P_OV_T][15:0];
		cond[P_UV_A] = lineVolt < r.prot[P_UV_A][15:0];
		cond[P_UV_T] = lineVolt < r.prot[P_UV_T][15:0];
		cond[P_FRQ_T] = dev > r.prot[P_FRQ_T][15:0]; // RULE_20
		cond[P_LD_A] = pfLead && pfPct < r.prot[P_LD_A][15:0]; // RULE_21
		cond[P_LD_T] = pfLead && pfPct < r.prot[P_LD_T][15:0]; // RULE_21
		cond[P_LG_A] = !pfLead && pfPct < r.prot[P_LG_A][15:0]; // RULE_21
		cond[P_LG_T] = !pfLead && pfPct < r.prot[P_LG_T][15:0]; // RULE_21
		cond[P_PL_T] = phaseLost; // RULE_18
		cond = cond & pEn;
		for (int i = 0; i < NPROT; i++) begin
			if (!cond[i]) begin
				n.pcnt[i] = 16'h0000; // RULE_24
			end else if (r.tick && r.pcnt[i] < {1'b0, r.prot[i][30:P_DLY]}) begin
				n.pcnt[i] = r.pcnt[i] + 16'h0001; // RULE_25
			end
			if (cond[i] && r.pcnt[i] >= {1'b0, r.prot[i][30:P_DLY]}) begin
				n.evt[i] = 1'b1; // RULE_16
			end
		end
		tripNow = (|(r.evt & TRIP_MASK)) || thermalTrip;

		////////////////////////////////////////////////////////////////////
		// Start and stop sequencer
		unique case (r.st)
			S_IDLE: begin
				n.fire = 16'h0000;
				n.fireEn = 1'b0;
				if (startCmd && !tripNow && reverseSeen != r.ctrl[C_REV]) begin
					n.evt[E_ROT] = 1'b1; // RULE_19
				end else if (startCmd && !tripNow) begin
					n.rampRef = r.initPct; // RULE_01 RULE_06
					n.err = 32'h0000_0000;
					n.phMs = 32'h0000_0000;
					n.runMs = 32'h0000_0000;
					n.atMs = 32'h0000_0000;
					n.limHit = 1'b0;
					n.fireEn = 1'b1;
					n.st = r.ctrl[C_KICK] ? S_KICK : S_RAMP;
				end
			end
			S_KICK: begin
				n.fire = {8'h00, r.kick[7:0]}; // RULE_11
				if (r.tick) begin
					n.phMs = r.phMs + 32'h0000_0001;
				end
				if (r.phMs >= 32'(r.kick[K_MS +: 16])) begin
					n.st = S_RAMP; // RULE_11
				end
			end
			S_RAMP: begin
				unique case (mode)
					M_CUR: tgt = r.limPct;
					M_PWR: tgt = r.maxPwr; // RULE_09
					default: tgt = FULL_PCT;
				endcase
				// Spread the rise evenly so the target lands at the ramp time
				delta = (tgt > r.initPct) ? 32'(tgt - r.initPct) : 32'h0000_0000;
				if (r.tick) begin
					n.err = r.err + delta; // RULE_02 RULE_07
				end else if (r.err >= rampMs && r.rampRef < tgt) begin
					n.rampRef = r.rampRef + 16'h0001; // RULE_02 RULE_07
					n.err = r.err - rampMs;
				end
				unique case (mode)
					M_CUR: if (r.tick) begin
						n.fire = step(r.fire, motorCur, r.rampRef); // RULE_05
					end
					M_PWR: if (r.tick) begin
						n.fire = step(r.fire, r.pwr, r.rampRef); // RULE_08
					end
					default: if (!r.limHit && motorCur < r.limPct) begin
						n.fire = r.rampRef; // RULE_04
					end else begin
						n.limHit = 1'b1;
						if (r.tick) begin
							n.fire = step(r.fire, motorCur, r.limPct); // RULE_03 RULE_04
						end
					end
				endcase
				if (atSpeed) begin
					n.st = S_RUN; // RULE_03
					n.fire = FULL_PCT;
				end
			end
			S_RUN: n.fire = FULL_PCT;
			S_DECEL: begin
				n.fire = r.rampRef;
				delta = 32'(r.decel[7:0]) - 32'(r.decel[D_STP +: 8]);
				if (r.rampRef <= 16'(r.decel[D_STP +: 8])) begin
					n.st = S_IDLE; // RULE_12
					n.fire = 16'h0000;
					n.fireEn = 1'b0;
				end else if (r.tick) begin
					n.err = r.err + delta;
				end else if (r.err >= decelMs) begin
					n.rampRef = r.rampRef - 16'h0001; // RULE_12
					n.err = r.err - decelMs;
				end
			end
			default: n.st = S_IDLE;
		endcase

		// Trips win over stop; an overload trip also ends current limit
		if (tripNow && r.st != S_IDLE) begin
			n.st = S_IDLE; // RULE_03
			n.fire = 16'h0000;
			n.fireEn = 1'b0;
		end else if (stopCmd && r.st inside {S_KICK, S_RAMP, S_RUN}) begin
			if (r.ctrl[C_DECEL]) begin
				n.st = S_DECEL; // RULE_12
				n.rampRef = {8'h00, r.decel[7:0]};
				n.fire = {8'h00, r.decel[7:0]};
				n.err = 32'h0000_0000;
			end else begin
				n.st = S_IDLE;
				n.fire = 16'h0000;
				n.fireEn = 1'b0;
			end
		end

		////////////////////////////////////////////////////////////////////
		// Start-related relays
		act = n.st inside {S_KICK, S_RAMP, S_RUN};
		if (act && r.tick && r.runMs != 32'hFFFF_FFFF) begin
			n.runMs = r.runMs + 32'h0000_0001; // RULE_25
		end
		if (act && atSpeed && r.tick && r.atMs != 32'hFFFF_FFFF) begin
			n.atMs = r.atMs + 32'h0000_0001;
		end
		n.timedRly = act && r.runMs >= 32'(32'(r.relay[7:0]) * MS_PER_S)
			+ 32'(32'(r.relay[R_RUN +: 8]) * MS_PER_S); // RULE_13
		n.runDlyRly = act && r.runMs < 32'(32'(r.relay[R_RUN +: 8]) * MS_PER_S); // RULE_14
		if (!act) begin
			n.atRly = 1'b0;
		end else if (atSpeed && r.atMs >= 32'(32'(r.relay[R_ATS +: 8]) * MS_PER_S)) begin
			n.atRly = 1'b1; // RULE_15
		end
		n.alarmOut = |(n.evt & ~TRIP_MASK);
		n.tripOut = |(n.evt & TRIP_MASK);

		////////////////////////////////////////////////////////////////////
		// Demand: one shared divider walks the four sums after each period
		if (r.dIdx < DIDX_IDLE) begin
			n.dAvg[r.dIdx[1:0]] = (r.dLcnt == 32'h0000_0000) ? 16'h0000
				: 16'(r.dLat[r.dIdx[1:0]] / 40'(r.dLcnt)); // RULE_22
			n.dIdx = r.dIdx + 3'h1;
		end
		if (r.tick && r.dMs >= ms1(r.demSec) - 32'h0000_0001) begin
			n.dMs = 32'h0000_0000;
			n.dLat = r.dSum;
			n.dLcnt = r.dCnt;
			n.dSum = '0;
			n.dCnt = 32'h0000_0000;
			n.dIdx = 3'h0;
		end else if (r.tick) begin
			n.dMs = r.dMs + 32'h0000_0001;
		end
		if (lineCycle) begin
			for (int k = 0; k < 4; k++) begin
				n.dSum[k] = n.dSum[k] + 40'(dq[k]); // RULE_22
			end
			n.dCnt = n.dCnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0; // RULE_25
			r.initPct <= INIT_RST;
			r.limPct <= LIM_RST;
			r.maxPwr <= MAXP_RST;
			r.rampSec <= RAMP_RST;
			r.demSec <= DEM_RST;
			r.dIdx <= DIDX_IDLE;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign fireLevel = r.fire;
	assign fireEnable = r.fireEn;
	assign timedRelay = r.timedRly;
	assign runDelayRelay = r.runDlyRly;
	assign atSpeedRelay = r.atRly;
	assign alarmOut = r.alarmOut;
	assign tripOut = r.tripOut;

endmodule
`default_nettype wire

// ==== core/ssr_pkg.sv ====
package ssr_pkg;
	// Timing
	localparam int CLK_NS  = 4;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [31:0] MS_PER_S = 32'h0000_03E8;
	// Register map, byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_INIT  = 8'h08;
	localparam logic [7:0] A_LIM   = 8'h0C;
	localparam logic [7:0] A_MAXP  = 8'h10;
	localparam logic [7:0] A_RAMP  = 8'h14;
	localparam logic [7:0] A_KICK  = 8'h18;
	localparam logic [7:0] A_DECEL = 8'h1C;
	localparam logic [7:0] A_RELAY = 8'h20;
	localparam logic [7:0] A_DEM   = 8'h24;
	localparam logic [7:0] A_EVT   = 8'h28;
	localparam logic [7:0] A_FIRE  = 8'h2C;
	localparam logic [7:0] A_DAVG  = 8'h30;
	localparam logic [7:0] A_PROT  = 8'h40;
	localparam logic [7:0] A_PEND  = 8'h88;
	// Control bits
	localparam int C_START = 0;
	localparam int C_STOP  = 1;
	localparam int C_KICK  = 2;
	localparam int C_DECEL = 3;
	localparam int C_MODE  = 4;
	localparam int C_REV   = 6;
	localparam int C_F60   = 7;
	localparam logic [31:0] CTRL_KEEP = 32'h0000_00FC;
	// Field positions
	localparam int K_MS  = 16;
	localparam int D_STP = 8;
	localparam int D_SEC = 16;
	localparam int R_RUN = 8;
	localparam int R_ATS = 16;
	localparam int P_DLY = 16;
	localparam int P_EN  = 31;
	// Reset values
	localparam logic [15:0] INIT_RST = 16'h0014;
	localparam logic [15:0] LIM_RST  = 16'h012C;
	localparam logic [15:0] MAXP_RST = 16'h0050;
	localparam logic [7:0]  RAMP_RST = 8'h0A;
	localparam logic [7:0]  DEM_RST  = 8'h0F;
	localparam logic [2:0]  DIDX_IDLE = 3'h4;
	// Scaling
	localparam logic [15:0] FULL_PCT = 16'h0064;
	localparam logic [15:0] FREQ50   = 16'h01F4;
	localparam logic [15:0] FREQ60   = 16'h0258;
	localparam logic [47:0] PWR_DIV  = 48'h0000_0000_2710;
	localparam logic [31:0] KVA_DIV  = 32'h0000_0064;
	// Protection channels
	localparam int NPROT = 18;
	localparam int NEVT  = 19;
	localparam int P_IMB_A = 0;
	localparam int P_IMB_T = 1;
	localparam int P_UC_A  = 2;
	localparam int P_OC_A  = 3;
	localparam int P_OC_T  = 4;
	localparam int P_GF_A  = 5;
	localparam int P_GF_L  = 6;
	localparam int P_GF_H  = 7;
	localparam int P_OV_A  = 8;
	localparam int P_OV_T  = 9;
	localparam int P_UV_A  = 10;
	localparam int P_UV_T  = 11;
	localparam int P_FRQ_T = 12;
	localparam int P_LD_A  = 13;
	localparam int P_LD_T  = 14;
	localparam int P_LG_A  = 15;
	localparam int P_LG_T  = 16;
	localparam int P_PL_T  = 17;
	localparam int E_ROT   = 18;
	localparam logic [NEVT-1:0] TRIP_MASK = 19'h75AD2;
	// AXI responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [1:0] {
		M_VOLT = 2'h0,
		M_CUR  = 2'h1,
		M_PWR  = 2'h2
	} ssr_mode_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_KICK  = 3'h1,
		S_RAMP  = 3'h3,
		S_RUN   = 3'h2,
		S_DECEL = 3'h6
	} ssr_state_t;

	typedef struct packed {
		ssr_state_t                st;
		logic [31:0]               tickCnt;
		logic                      tick;
		logic [31:0]               ctrl;
		logic [31:0]               kick;
		logic [31:0]               decel;
		logic [31:0]               relay;
		logic [15:0]               initPct;
		logic [15:0]               limPct;
		logic [15:0]               maxPwr;
		logic [7:0]                rampSec;
		logic [7:0]                demSec;
		logic [NPROT-1:0][31:0]    prot;
		logic [NPROT-1:0][15:0]    pcnt;
		logic [NEVT-1:0]           evt;
		logic [15:0]               rampRef;
		logic [15:0]               fire;
		logic [15:0]               pwr;
		logic [15:0]               kva;
		logic [31:0]               err;
		logic [31:0]               phMs;
		logic [31:0]               runMs;
		logic [31:0]               atMs;
		logic                      limHit;
		logic                      fireEn;
		logic                      timedRly;
		logic                      runDlyRly;
		logic                      atRly;
		logic                      alarmOut;
		logic                      tripOut;
		logic [3:0][39:0]          dSum;
		logic [3:0][39:0]          dLat;
		logic [31:0]               dCnt;
		logic [31:0]               dLcnt;
		logic [31:0]               dMs;
		logic [2:0]                dIdx;
		logic [3:0][15:0]          dAvg;
		logic                      awHave;
		logic                      wHave;
		logic                      awready;
		logic                      wready;
		logic                      bvalid;
		logic                      arready;
		logic                      rvalid;
		logic [31:0]               awAddr;
		logic [31:0]               wData;
		logic [31:0]               rdata;
		logic [3:0]                wStrb;
		logic [1:0]                bresp;
		logic [1:0]                rresp;
	} ssr_regs_t;
endpackage

// ==== sim/ssr_line_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssr_line_model
	import ssr_pkg::*;
#(
	parameter int PER = 40
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Measurements
	output logic             lineCycle,
	output logic             pfLead,
	output logic             phaseLost,
	output logic [15:0]      lineVolt,
	output logic [15:0]      pfPct,
	output logic [15:0]      imbalance,
	output logic [15:0]      groundCur,
	output logic [15:0]      lineFreq,
	output logic [15:0]      kvarPct
);
	int n;
	// Short line cycle keeps demand sums busy
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) n <= 0;
		else n <= (n == PER - 1) ? 0 : n + 1;
	assign lineCycle = (n == PER - 1);
	assign pfLead    = 1'b0;
	assign phaseLost = 1'b0;
	assign lineVolt  = FULL_PCT;
	assign pfPct     = 16'h005A;
	assign imbalance = 16'h0001;
	assign groundCur = 16'h0000;
	assign lineFreq  = FREQ50;
	assign kvarPct   = 16'h0014;
endmodule
`default_nettype wire

// ==== sim/ssr_core_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssr_core_chk (
	// Bus and outputs seen at the top
	input wire logic        clk_sys, reset_n, awvalid, awready, wvalid, wready,
	input wire logic        bvalid, bready, arvalid, arready, rvalid, rready,
	input wire logic        fireEnable, timedRelay, atSpeedRelay, tripOut,
	input wire logic [1:0]  bresp,
	input wire logic [31:0] rdata,
	input wire logic [15:0] fireLevel
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_wTake; awvalid && awready && wvalid && wready; endsequence
	sequence s_off; ##[0:2] !fireEnable; endsequence
	// Response rises one edge after both halves are held
	property p_wAns; s_wTake |=> ##1 bvalid; endproperty
	property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	property p_rAns; arvalid && arready |=> rvalid; endproperty
	property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	property p_arLow; rvalid |-> !arready; endproperty
	property p_tripOff; tripOut |-> s_off; endproperty
	property p_rlyDrop; $fell(fireEnable) |-> ##[0:2] !timedRelay && !atSpeedRelay; endproperty
	property p_idleZero; !fireEnable |-> ##[0:2] fireLevel == 16'h0000; endproperty
	a_wAns: assert property (p_wAns) else $error("write answer late");
	a_bHold: assert property (p_bHold) else $error("write answer dropped");
	a_rAns: assert property (p_rAns) else $error("read answer late");
	a_rHold: assert property (p_rHold) else $error("read answer dropped");
	a_arLow: assert property (p_arLow) else $error("read taken while busy");
	a_tripOff: assert property (p_tripOff) else $error("firing during trip");
	a_rlyDrop: assert property (p_rlyDrop) else $error("relay held idle");
	a_idleZero: assert property (p_idleZero) else $error("output left on");
endmodule
bind ssr_core ssr_core_chk chk(.*);
`default_nettype wire

// ==== sim/soft_start_ramp_protection_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module soft_start_ramp_protection_test
	import ssr_pkg::*;
;
	localparam int TK = 10;
	logic        clk_sys = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, reverseSeen = 0, atSpeed = 0, thermalTrip = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd, ini, hi;
	logic [3:0]  wstrb = 4'hF;
	logic [15:0] motorCur = 0, fireLevel, lineVolt, pfPct, imbalance;
	logic [15:0] groundCur, lineFreq, kvarPct;
	logic        awready, wready, bvalid, arready, rvalid, lineCycle, pfLead, phaseLost;
	logic        fireEnable, timedRelay, runDelayRelay, atSpeedRelay, alarmOut, tripOut;
	logic [1:0]  bresp, rresp, rs;
	int          errors = 0, n_checks = 0, cyc = 0;
	logic [31:0] seed = 32'h23E0;
	int          mdl[logic [7:0]] = '{A_INIT:20, A_LIM:300, A_MAXP:80, A_RAMP:10, A_DEM:15};
	ssr_core #(.TICK_CYCLES(TK)) dut(.*);
	ssr_line_model line(.*);
	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cyc == 90000) begin
		errors++;
		results();
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge clk_sys);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				bready <= 0;
				rs = bresp;
				break;
			end
		end
	endtask
	task automatic rdr(logic [7:0] a);
		@(posedge clk_sys);
		araddr <= {24'h0, a};
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge clk_sys);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				rready <= 0;
				rd = rdata;
				rs = rresp;
				break;
			end
		end
	endtask
	task automatic wm(logic [7:0] a, logic [31:0] d);
		wr(a, d);
		mdl[a] = d;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		ini = 10 + rnd() % 40;
		hi = 401 + rnd() % 100;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1;
		foreach (mdl[a]) begin rdr(a); chk("reg", mdl[a], rd); end
		rdr(8'h88);
		chk("rresp", RESP_ERR, rs);
		wr(8'h88, 0);
		chk("bresp", RESP_ERR, rs);
		wm(A_INIT, ini);
		wm(A_RAMP, 1);
		wm(A_RELAY, 32'h0000_0100);
		wm(A_DECEL, 32'h0001_143C);
		// Trip level above the limit-phase current, so the start is not tripped
		wm(8'h50, 32'h8005_0190);
		foreach (mdl[a]) begin rdr(a); chk("reg", mdl[a], rd); end
		wr(A_CTRL, 32'h9);
		rdr(A_FIRE);
		chk("ref0", ini, rd[31:16]);
		chk("run0", 2'b11, {fireEnable, runDelayRelay});
		// Ramp of one second is 1000 ticks
		repeat (1010 * TK) @(posedge clk_sys);
		rdr(A_FIRE);
		chk("ref1", 100, rd[31:16]);
		chk("rly", 2'b10, {timedRelay, runDelayRelay});
		motorCur <= 16'h015E;
		repeat (50 * TK) @(posedge clk_sys);
		chk("lim", 1, fireLevel < 100);
		atSpeed <= 1;
		repeat (3 * TK) @(posedge clk_sys);
		rdr(A_STAT);
		chk("run", {S_RUN, 16'h0064, 1'b1}, {rd[2:0], fireLevel, atSpeedRelay});
		wr(A_CTRL, 32'hA);
		atSpeed <= 0;
		motorCur <= 0;
		repeat (2) @(posedge clk_sys);
		chk("dec0", 18'h3C, {timedRelay, atSpeedRelay, fireLevel});
		repeat (1010 * TK) @(posedge clk_sys);
		chk("dec1", 0, {fireEnable, fireLevel});
		// A broken run of overcurrent must not add up
		motorCur <= hi[15:0];
		repeat (3 * TK) @(posedge clk_sys);
		motorCur <= 0;
		repeat (3 * TK) @(posedge clk_sys);
		motorCur <= hi[15:0];
		repeat (3 * TK) @(posedge clk_sys);
		chk("oc0", 0, tripOut);
		repeat (4 * TK) @(posedge clk_sys);
		chk("oc1", 1, tripOut);
		motorCur <= 0;
		wr(A_EVT, 32'h10);
		rdr(A_EVT);
		chk("ocClr", 0, {tripOut, rd[P_OC_T]});
		// Imbalance alarm set below its trip level
		wr(8'h44, 32'h8000_0005);
		wr(8'h40, 32'h8000_0000);
		repeat (3) @(posedge clk_sys);
		rdr(A_EVT);
		chk("imb", 3'b101, {alarmOut, rd[P_IMB_T], rd[P_IMB_A]});
		reverseSeen <= 1;
		wr(A_CTRL, 32'h1);
		repeat (3) @(posedge clk_sys);
		rdr(A_EVT);
		chk("rot", 3'b110, {rd[E_ROT], tripOut, fireEnable});
		results();
	end
endmodule
`default_nettype wire
